// ===== common/fuse_decode_params.svh
// Constants for the fuse lock and configuration decoder: offsets, word indices,
// field positions and fixed values. Assumes inclusion by bare name.
`ifndef FUSE_DECODE_PARAMS_SVH
`define FUSE_DECODE_PARAMS_SVH

// ****************************************************************************
// Shadow word and soft fuse offsets (byte offsets within the fuse controller map).
// ****************************************************************************
`define OFS_REGION_LOCK 12'h400
`define OFS_CHALLENGE 12'h410
`define OFS_CHALLENGE_HI 12'h420
`define OFS_SPEED_GRADE 12'h440
`define OFS_FEATURE_DIS 12'h450
`define OFS_BOOT_SEC 12'h470
`define OFS_BOOT_PARAM_A 12'h480
`define OFS_BOOT_PARAM_B 12'h490
`define OFS_BOOT_PARAM_C 12'h4a0
`define OFS_BOOT_PARAM_D 12'h4b0
`define OFS_ROOT_DIGEST 12'h580
`define OFS_DBG_RESP 12'h600
`define OFS_DBG_RESP_HI 12'h610
`define OFS_USB_ID 12'h620
`define OFS_RETURN_TEST 12'h630
`define OFS_NET_ID 12'h640
`define OFS_KEY_REVOKE 12'h670
`define OFS_GENERAL_A 12'h780
`define OFS_GENERAL_B 12'h7a0
`define OFS_GENERAL_C 12'h800
`define OFS_SOFT_FUSE 12'h060

// ****************************************************************************
// Word indices into the shadow array.
// ****************************************************************************
`define NUM_WORDS 20
`define IDX_REGION_LOCK 5'h00
`define IDX_CHALLENGE 5'h01
`define IDX_CHALLENGE_HI 5'h02
`define IDX_SPEED_GRADE 5'h03
`define IDX_FEATURE_DIS 5'h04
`define IDX_BOOT_SEC 5'h05
`define IDX_BOOT_PARAM_A 5'h06
`define IDX_BOOT_PARAM_B 5'h07
`define IDX_BOOT_PARAM_C 5'h08
`define IDX_BOOT_PARAM_D 5'h09
`define IDX_ROOT_DIGEST 5'h0a
`define IDX_DBG_RESP 5'h0b
`define IDX_DBG_RESP_HI 5'h0c
`define IDX_USB_ID 5'h0d
`define IDX_RETURN_TEST 5'h0e
`define IDX_NET_ID 5'h0f
`define IDX_KEY_REVOKE 5'h10
`define IDX_GENERAL_A 5'h11
`define IDX_GENERAL_B 5'h12
`define IDX_GENERAL_C 5'h13

// ****************************************************************************
// Field positions and fixed values.
// ****************************************************************************
`define POISON_WORD 32'hbadabada
`define FREQ_TOP_MHZ 12'h8fc
`define FREQ_STEP_MHZ 12'h064
`define BOOT_MODE_DEV 2'h0
`define BOOT_MODE_PROD 2'h2

`endif

// ===== common/fuse_decode_pkg.sv
// Types shared by the fuse lock and configuration decoder.
// Assumes the constants header is on the include path.
`default_nettype none

package fuse_decode_pkg;

    `include "fuse_decode_params.svh"

    // Lock region that governs a shadow word.
    typedef enum logic [3:0] {
        RGN_NONE, RGN_TESTER, RGN_BOOT, RGN_DIGEST, RGN_RESP,
        RGN_USB, RGN_NET, RGN_GEN_A, RGN_GEN_B, RGN_GEN_C, RGN_LOCKWORD
    } region_e;

    // Lifecycle state decoded from the two security bits.
    typedef enum logic [1:0] {LC_FACTORY, LC_OPEN, LC_CLOSED} lifecycle_e;

    // Boot source chosen by the boot mode and the fuse-select bit.
    typedef enum logic [1:0] {BOOT_PINS, BOOT_FUSES, BOOT_SERIAL} boot_src_e;

    // Permissions of one controlled field.
    typedef struct packed {
        logic rd;
        logic sense;
        logic burn;
        logic ovr;
    } perm_s;

    // Shadow access request.
    typedef struct packed {
        logic req;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } acc_req_s;

    // Decoded configuration for on-chip consumers.
    typedef struct packed {
        logic [2:0] core_count;
        logic core_code_reserved;
        logic [11:0] freq_mhz;
        lifecycle_e lifecycle_state;
        logic security_debug_block;
        logic crypto_disable;
        logic [8:0] unit_disable;
        logic trace_allowed;
        logic secure_debug_ctrl_off;
        logic [1:0] debug_security_level;
        logic debug_grant;
        boot_src_e boot_source;
        logic reset_ctrl_boot_mirror;
        logic field_return;
        logic [3:0] key_revocation_mask;
        logic [55:0] debug_response_value;
    } cfg_s;

    // Whole state of the decoder.
    typedef struct packed {
        logic [`NUM_WORDS-1:0][31:0] shadow;
        logic boot_auth_debug_grant;
        logic loaded;
        logic err;
        logic ack;
        logic [31:0] rdata;
        logic burn_ok;
        logic burn_refused;
        logic [2:0][1:0] mode_sync;
        logic [1:0] boot_mode;
        cfg_s cfg;
    } state_s;

endpackage

`default_nettype wire

// ===== src/fuse_lock_and_config_decode.sv
// Fuse shadow store with lock-region permission checks and configuration decode.
// Assumes the fuse sequencer feeds the shadow words after reset and pulses done,
// and that access and burn requests come from logic on the same clock.
`default_nettype none

module fuse_lock_and_config_decode
    import fuse_decode_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Fuse sequencer load port.
    input wire logic i_load_valid,
    input wire logic [11:0] i_load_addr,
    input wire logic [31:0] i_load_data,
    input wire logic i_load_done,
    // Shadow access port.
    input wire acc_req_s i_acc,
    input wire logic i_err_clear,
    output logic o_ack,
    output logic [31:0] o_rdata,
    output logic o_err,
    // Fuse burn permission check.
    input wire logic i_burn_req,
    input wire logic [11:0] i_burn_addr,
    output logic o_burn_ok,
    output logic o_burn_refused,
    // Boot mode pins, asynchronous.
    input wire logic [1:0] i_boot_mode,
    // Decoded configuration.
    output logic o_fuse_latched,
    output cfg_s o_cfg
);

    // ************************************************************************
    // Helper functions.
    // ************************************************************************

    // Maps a byte offset to a shadow index; hit is low for unmapped offsets.
    function automatic logic [5:0] word_of(input logic [11:0] a);
        logic [5:0] r;
        r = 6'h00;
        if (a == `OFS_REGION_LOCK) begin
            r = {1'b1, `IDX_REGION_LOCK};
        end else if (a == `OFS_CHALLENGE) begin
            r = {1'b1, `IDX_CHALLENGE};
        end else if (a == `OFS_CHALLENGE_HI) begin
            r = {1'b1, `IDX_CHALLENGE_HI};
        end else if (a == `OFS_SPEED_GRADE) begin
            r = {1'b1, `IDX_SPEED_GRADE};
        end else if (a == `OFS_FEATURE_DIS) begin
            r = {1'b1, `IDX_FEATURE_DIS};
        end else if (a == `OFS_BOOT_SEC) begin
            r = {1'b1, `IDX_BOOT_SEC};
        end else if (a == `OFS_BOOT_PARAM_A) begin
            r = {1'b1, `IDX_BOOT_PARAM_A};
        end else if (a == `OFS_BOOT_PARAM_B) begin
            r = {1'b1, `IDX_BOOT_PARAM_B};
        end else if (a == `OFS_BOOT_PARAM_C) begin
            r = {1'b1, `IDX_BOOT_PARAM_C};
        end else if (a == `OFS_BOOT_PARAM_D) begin
            r = {1'b1, `IDX_BOOT_PARAM_D};
        end else if (a == `OFS_ROOT_DIGEST) begin
            r = {1'b1, `IDX_ROOT_DIGEST};
        end else if (a == `OFS_DBG_RESP) begin
            r = {1'b1, `IDX_DBG_RESP};
        end else if (a == `OFS_DBG_RESP_HI) begin
            r = {1'b1, `IDX_DBG_RESP_HI};
        end else if (a == `OFS_USB_ID) begin
            r = {1'b1, `IDX_USB_ID};
        end else if (a == `OFS_RETURN_TEST) begin
            r = {1'b1, `IDX_RETURN_TEST};
        end else if (a == `OFS_NET_ID) begin
            r = {1'b1, `IDX_NET_ID};
        end else if (a == `OFS_KEY_REVOKE) begin
            r = {1'b1, `IDX_KEY_REVOKE};
        end else if (a == `OFS_GENERAL_A) begin
            r = {1'b1, `IDX_GENERAL_A};
        end else if (a == `OFS_GENERAL_B) begin
            r = {1'b1, `IDX_GENERAL_B};
        end else if (a == `OFS_GENERAL_C) begin
            r = {1'b1, `IDX_GENERAL_C};
        end
        return r;
    endfunction

    // Names the lock region that governs a shadow word.
    function automatic region_e region_of(input logic [4:0] idx);
        region_e r;
        r = RGN_NONE;
        if (idx == `IDX_REGION_LOCK) begin
            r = RGN_LOCKWORD;
        end else if (idx >= `IDX_CHALLENGE && idx <= `IDX_FEATURE_DIS) begin
            r = RGN_TESTER;
        end else if (idx >= `IDX_BOOT_SEC && idx <= `IDX_BOOT_PARAM_D) begin
            r = RGN_BOOT;
        end else if (idx == `IDX_ROOT_DIGEST) begin
            r = RGN_DIGEST;
        end else if (idx == `IDX_DBG_RESP || idx == `IDX_DBG_RESP_HI) begin
            r = RGN_RESP;
        end else if (idx == `IDX_USB_ID) begin
            r = RGN_USB;
        end else if (idx == `IDX_NET_ID) begin
            r = RGN_NET;
        end else if (idx == `IDX_GENERAL_A) begin
            r = RGN_GEN_A;
        end else if (idx == `IDX_GENERAL_B) begin
            r = RGN_GEN_B;
        end else if (idx == `IDX_GENERAL_C) begin
            r = RGN_GEN_C;
        end
        return r;
    endfunction

    // Turns a two-bit lock code into permissions.
    function automatic perm_s perm_of_code(input logic [1:0] code);
        perm_s p;
        p = '{rd: 1'b1, sense: 1'b1, burn: 1'b1, ovr: 1'b1};
        p.ovr = ~code[1];
        p.burn = ~code[0];
        return p;
    endfunction

    // Permissions of a shadow word under the current lock word.
    function automatic perm_s perm_of(input logic [4:0] idx, input logic [31:0] lk);
        perm_s p;
        p = perm_of_code(2'h0);
        case (region_of(idx))
            RGN_TESTER: p = perm_of_code(lk[1:0]);
            RGN_BOOT: p = perm_of_code(lk[3:2]);
            RGN_DIGEST: p = perm_of_code({lk[9], lk[9]});
            RGN_RESP: p = lk[10] ? perm_s'{rd: 1'b0, sense: 1'b0, burn: 1'b0, ovr: 1'b0} : p;
            // undefined override-only code is treated as both protections.
            RGN_USB: p = perm_of_code(lk[13:12] == 2'h2 ? 2'h3 : lk[13:12]);
            RGN_NET: p = perm_of_code(lk[15:14]);
            RGN_GEN_A: p = perm_of_code(lk[21:20]);
            RGN_GEN_B: p = perm_of_code(lk[23:22]);
            RGN_GEN_C: p = perm_of_code(lk[25:24]);
            // The lock word itself is read only and never burned here.
            RGN_LOCKWORD: p = '{rd: 1'b1, sense: 1'b1, burn: 1'b0, ovr: 1'b0};
            default: p = perm_of_code(2'h0);
        endcase
        return p;
    endfunction

    // ************************************************************************
    // State.
    // ************************************************************************

    // Registered state and its next value.
    state_s s_q;
    state_s s_d;

    // ************************************************************************
    // Next-state logic.
    // ************************************************************************

    // Load, access, burn check, pin sync and configuration decode in one pass.
    always_comb begin
        logic [5:0] hit;
        logic [5:0] bhit;
        logic [5:0] lhit;
        perm_s p;
        perm_s bp;
        logic set_err;
        logic [31:0] lk;
        logic [31:0] fd;
        logic [31:0] bs;
        s_d = s_q;
        set_err = 1'b0;
        lk = s_q.shadow[`IDX_REGION_LOCK];
        fd = s_q.shadow[`IDX_FEATURE_DIS];
        bs = s_q.shadow[`IDX_BOOT_SEC];
        hit = word_of(i_acc.addr);
        p = perm_of(hit[4:0], lk);
        bhit = word_of(i_burn_addr);
        bp = perm_of(bhit[4:0], lk);
        lhit = word_of(i_load_addr);
        s_d.ack = 1'b0;
        s_d.burn_ok = 1'b0;
        s_d.burn_refused = 1'b0;

        // Sequencer fills shadows regardless of lock state.
        if (i_load_valid && lhit[5]) begin
            s_d.shadow[lhit[4:0]] = i_load_data;
        end
        if (i_load_done) begin
            s_d.loaded = 1'b1;
        end

        // Shadow and soft fuse access, one-cycle acknowledge.
        if (i_acc.req) begin
            s_d.ack = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (i_acc.addr == `OFS_SOFT_FUSE) begin
                if (i_acc.wr) begin
                    s_d.boot_auth_debug_grant = i_acc.wdata[0];
                end else begin
                    s_d.rdata = {31'h0000_0000, s_q.boot_auth_debug_grant};
                end
            end else if (hit[5] && !i_acc.wr) begin
                if (p.rd) begin
                    s_d.rdata = s_q.shadow[hit[4:0]];
                end else begin
                    s_d.rdata = `POISON_WORD;
                    set_err = 1'b1;
                end
            end else if (hit[5]) begin
                // locked write rejected; writes before load ends are refused too.
                if (p.ovr && s_q.loaded) begin
                    s_d.shadow[hit[4:0]] = i_acc.wdata;
                end else begin
                    set_err = 1'b1;
                end
            end
        end

        // Burn permission check answers one cycle later.
        if (i_burn_req) begin
            if (bhit[5] && bp.burn) begin
                s_d.burn_ok = 1'b1;
            end else begin
                s_d.burn_refused = 1'b1;
                set_err = 1'b1;
            end
        end

        // A new error in the clearing cycle wins over the clear.
        s_d.err = (s_q.err & ~i_err_clear) | set_err;

        // Boot mode pins: accepted once the second and third stages agree.
        s_d.mode_sync = {s_q.mode_sync[1:0], i_boot_mode};
        if (s_q.mode_sync[1] == s_q.mode_sync[2]) begin
            s_d.boot_mode = s_q.mode_sync[2];
        end

        case (fd[1:0])
            2'h0: s_d.cfg.core_count = 3'h4;
            2'h2: s_d.cfg.core_count = 3'h2;
            2'h3: s_d.cfg.core_count = 3'h1;
            default: s_d.cfg.core_count = 3'h0;
        endcase
        s_d.cfg.core_code_reserved = (fd[1:0] == 2'h1);
        s_d.cfg.freq_mhz = `FREQ_TOP_MHZ
            - 12'(`FREQ_STEP_MHZ * {8'h00, s_q.shadow[`IDX_SPEED_GRADE][11:8]});
        if (bs[25]) begin
            s_d.cfg.lifecycle_state = LC_CLOSED;
        end else if (fd[17]) begin
            s_d.cfg.lifecycle_state = LC_OPEN;
        end else begin
            s_d.cfg.lifecycle_state = LC_FACTORY;
        end
        s_d.cfg.security_debug_block = bs[25];
        s_d.cfg.crypto_disable = fd[16];
        s_d.cfg.unit_disable = {fd[31:28], fd[24], fd[11:8]};
        s_d.cfg.secure_debug_ctrl_off = bs[21];
        s_d.cfg.debug_security_level = bs[21] ? 2'h3 : bs[23:22];
        s_d.cfg.trace_allowed = ~bs[20] | (~bs[21] & (bs[23:22] == 2'h0));
        s_d.cfg.debug_grant = s_q.boot_auth_debug_grant & ~bs[26];
        if (bs[28]) begin
            s_d.cfg.boot_source = BOOT_FUSES;
        end else if (s_q.boot_mode == `BOOT_MODE_PROD) begin
            s_d.cfg.boot_source = BOOT_SERIAL;
        end else begin
            s_d.cfg.boot_source = BOOT_PINS;
        end
        s_d.cfg.reset_ctrl_boot_mirror = bs[29];
        s_d.cfg.field_return = s_q.shadow[`IDX_RETURN_TEST][0];
        s_d.cfg.key_revocation_mask = s_q.shadow[`IDX_KEY_REVOKE][3:0];
        s_d.cfg.debug_response_value = {s_q.shadow[`IDX_DBG_RESP_HI][23:0], s_q.shadow[`IDX_DBG_RESP]};
    end

    // ************************************************************************
    // State register.
    // ************************************************************************

    // Resets to cleared shadows; the lock word reads zero until loaded, so
    // consumers must wait for the latched flag before trusting any decode.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************************
    // Outputs.
    // ************************************************************************

    // Every output is a field of the state register.
    assign o_ack = s_q.ack;
    assign o_rdata = s_q.rdata;
    assign o_err = s_q.err;
    assign o_burn_ok = s_q.burn_ok;
    assign o_burn_refused = s_q.burn_refused;
    assign o_fuse_latched = s_q.loaded;
    assign o_cfg = s_q.cfg;

endmodule

`default_nettype wire

// ===== sim/fuse_decode_sva.sv
// Port checker for the fuse lock and configuration decoder.
// Assumes one clock domain and an asynchronous active-high reset.
`default_nettype none
module fuse_decode_sva
    import fuse_decode_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_load_valid,
    input wire logic [11:0] i_load_addr,
    input wire logic [31:0] i_load_data,
    input wire logic i_load_done,
    input wire acc_req_s i_acc,
    input wire logic i_burn_req,
    input wire logic o_ack,
    input wire logic [31:0] o_rdata,
    input wire logic o_err,
    input wire logic o_burn_ok,
    input wire logic o_burn_refused,
    input wire logic o_fuse_latched,
    input wire cfg_s o_cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Response lock bit, tracked from the load port because software cannot write the lock word.
    logic lock_q;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lock_q <= 1'b0;
        end else if (i_load_valid && i_load_addr == 12'h400) begin
            lock_q <= i_load_data[10];
        end
    end
    a_ack_follows: assert property (i_acc.req |=> o_ack)
        else $error("ack missing after request");
    a_ack_only_req: assert property (!i_acc.req |=> !o_ack)
        else $error("ack without request");
    a_burn_answer: assert property (i_burn_req |=> o_burn_ok != o_burn_refused)
        else $error("burn check gave no single answer");
    a_refusal_flags: assert property (o_burn_refused |-> ##[0:1] o_err)
        else $error("refused burn left error clear");
    a_poison_read: assert property (i_acc.req && !i_acc.wr && i_acc.addr == 12'h600 && lock_q
        |=> o_rdata == 32'hbadabada ##[0:1] o_err) else $error("locked read not poisoned");
    a_lockword_write: assert property (i_acc.req && i_acc.wr && i_acc.addr == 12'h400 |=> ##[0:1] o_err)
        else $error("lock word write not flagged");
    a_latched_hold: assert property (i_load_done |=> o_fuse_latched [*4])
        else $error("latched flag not held");
    a_core_code: assert property (o_fuse_latched |-> (o_cfg.core_count inside {3'h0, 3'h1, 3'h2, 3'h4})
        && (o_cfg.core_code_reserved == (o_cfg.core_count == 3'h0))) else $error("core count bad");
    a_freq_grid: assert property (o_fuse_latched |-> o_cfg.freq_mhz >= 12'h320
        && o_cfg.freq_mhz <= 12'h8fc && (12'h8fc - o_cfg.freq_mhz) % 12'h064 == 12'h0) else $error("freq off grid");
    a_closed_block: assert property (o_cfg.security_debug_block == (o_cfg.lifecycle_state == LC_CLOSED))
        else $error("closed state not blocking");
    a_ctrl_off_level: assert property (o_cfg.secure_debug_ctrl_off |-> o_cfg.debug_security_level == 2'h3)
        else $error("controller off but debug level open");
    c_poison: cover property (o_rdata == 32'hbadabada);
    c_refused: cover property (o_burn_refused);
    c_closed: cover property (o_cfg.lifecycle_state == LC_CLOSED);
endmodule
bind fuse_lock_and_config_decode fuse_decode_sva u_fuse_decode_sva (.i_clock(i_clock), .i_rst(i_rst),
    .i_load_valid(i_load_valid), .i_load_addr(i_load_addr), .i_load_data(i_load_data), .i_load_done(i_load_done),
    .i_acc(i_acc), .i_burn_req(i_burn_req), .o_ack(o_ack), .o_rdata(o_rdata), .o_err(o_err),
    .o_burn_ok(o_burn_ok), .o_burn_refused(o_burn_refused), .o_fuse_latched(o_fuse_latched), .o_cfg(o_cfg));
`default_nettype wire

// ===== sim/fuse_array_model.sv
// Model of the fuse array sequencer that fills the shadow words.
// Assumes the bench calls its tasks after reset is released.
`default_nettype none
module fuse_array_model (
    // Clock.
    input wire logic i_clock,
    // Load port toward the decoder.
    output logic o_valid,
    output logic [11:0] o_addr,
    output logic [31:0] o_data,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_valid = 1'b0;
        o_addr = 12'h0;
        o_data = 32'h0;
        o_done = 1'b0;
    end
    // Word load; the released bus shows inverted data so stale values cannot pass.
    task automatic load(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        #1 {o_valid, o_addr, o_data} = {1'b1, a, d};
        @(posedge i_clock);
        #1 {o_valid, o_addr, o_data} = {1'b0, ~a, ~d};
    endtask
    // One-cycle end-of-load pulse.
    task automatic finish;
        @(posedge i_clock);
        #1 o_done = 1'b1;
        @(posedge i_clock);
        #1 o_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the fuse lock and configuration decoder.
// Assumes the checker is bound by its own file.
`default_nettype none
module testbench import fuse_decode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, lv, ld_done, err_clear, burn_req, ack, err, bok, bref, latched;
    logic [11:0] la, burn_addr;
    logic [31:0] ldat, rdata, rd;
    logic [1:0] boot_mode;
    logic [2:0] cores [4] = '{3'h4, 3'h0, 3'h2, 3'h1};
    acc_req_s acc;
    cfg_s cfg;
    int bad_count = 0, num_checks = 0;
    always #2.5 clock = ~clock;
    fuse_array_model u_fuse_array_model (.i_clock(clock), .o_valid(lv), .o_addr(la), .o_data(ldat), .o_done(ld_done));
    fuse_lock_and_config_decode u_fuse_lock_and_config_decode (.i_clock(clock), .i_rst(rst), .i_load_valid(lv),
        .i_load_addr(la), .i_load_data(ldat), .i_load_done(ld_done), .i_acc(acc), .i_err_clear(err_clear),
        .o_ack(ack), .o_rdata(rdata), .o_err(err), .i_burn_req(burn_req), .i_burn_addr(burn_addr),
        .o_burn_ok(bok), .o_burn_refused(bref), .i_boot_mode(boot_mode), .o_fuse_latched(latched), .o_cfg(cfg));
    // ************************************************************************
    // Access tasks.
    // ************************************************************************
    task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        #1 acc = '{1'b1, w, a, d};
        @(posedge clock);
        #1 acc.req = 1'b0;
        chk(56'(ack), 56'h1, "ack");
        rd = rdata;
    endtask
    task automatic clr;
        @(posedge clock);
        #1 err_clear = 1'b1;
        @(posedge clock);
        #1 err_clear = 1'b0;
    endtask
    task automatic burn(input logic [11:0] a, input logic ok);
        @(posedge clock);
        #1 {burn_req, burn_addr} = {1'b1, a};
        @(posedge clock);
        #1 burn_req = 1'b0;
        chk(56'({bok, bref}), 56'({ok, !ok}), "burn answer");
    endtask
    // Shadow load, then one more edge so the decode has settled.
    task automatic ld(input logic [11:0] a, input logic [31:0] d);
        u_fuse_array_model.load(a, d);
        @(posedge clock);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        complete_run;
    end
    // ************************************************************************
    // Main sequence.
    // ************************************************************************
    initial begin
        acc = '0;
        {err_clear, burn_req, burn_addr, boot_mode} = '0;
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        access(1'b1, 12'h480, 32'h1); chk(56'(err), 56'h1, "early write");
        clr;
        u_fuse_array_model.finish();
        @(posedge clock);
        #1 chk(56'(latched), 56'h1, "latched");
        for (int k = 0; k < 16; k++) begin
            ld(12'h450, {4'(k), 3'h0, 1'(k), 7'h0, 1'(k), 4'h0, 4'(k), 6'h0, 2'(k)});
            ld(12'h440, 32'(k) << 8);
            chk(56'({cfg.core_count, cfg.core_code_reserved}), 56'({cores[k % 4], 1'(k % 4 == 1)}), "cores");
            chk(56'(cfg.freq_mhz), 56'(2300 - 100 * k), "freq");
            chk(56'(cfg.crypto_disable), 56'(k % 2), "crypto");
            chk(56'(cfg.unit_disable), 56'({4'(k), 1'(k), 4'(k)}), "units");
        end
        for (int j = 0; j < 4; j++) begin
            ld(12'h450, 32'(j % 2) << 17);
            ld(12'h470, 32'(j / 2) << 25);
            chk(56'(cfg.lifecycle_state), 56'(j > 1 ? LC_CLOSED : (j ? LC_OPEN : LC_FACTORY)), "life");
            chk(56'(cfg.security_debug_block), 56'(j > 1), "block");
        end
        for (int t = 0; t < 8; t++) begin
            ld(12'h470, 32'(t % 4) << 20 | 32'(t / 4) << 22);
            chk(56'(cfg.debug_security_level), 56'(t % 4 > 1 ? 3 : t / 4), "level");
            chk(56'(cfg.secure_debug_ctrl_off), 56'(t % 4 > 1), "ctrl off");
            chk(56'(cfg.trace_allowed), 56'(t % 2 == 0 || (t % 4 < 2 && t < 4)), "trace");
        end
        access(1'b1, 12'h060, 32'h1);
        access(1'b0, 12'h060, 32'h0); chk(56'(rd[0]), 56'h1, "grant reg");
        ld(12'h470, 32'h0); chk(56'(cfg.debug_grant), 56'h1, "grant");
        ld(12'h470, 32'h1 << 26); chk(56'(cfg.debug_grant), 56'h0, "grant off");
        for (int m = 0; m < 4; m++) begin
            boot_mode = m > 1 ? 2'h2 : 2'h0;
            ld(12'h470, 32'(m % 2) << 28 | 32'(m / 2) << 29);
            repeat (8) @(posedge clock);
            #1 chk(56'(cfg.boot_source), 56'(m % 2 ? BOOT_FUSES : (m > 1 ? BOOT_SERIAL : BOOT_PINS)), "boot");
            chk(56'(cfg.reset_ctrl_boot_mirror), 56'(m / 2), "cold");
        end
        ld(12'h670, 32'h9); ld(12'h630, 32'h1);
        chk(56'({cfg.key_revocation_mask, cfg.field_return}), 56'h13, "revoke");
        ld(12'h600, 32'h89abcdef); ld(12'h610, 32'h123456);
        chk(cfg.debug_response_value, 56'h12345689abcdef, "response");
        for (int c = 0; c < 4; c++) begin
            ld(12'h400, 32'(c) << 2 | 32'(c) << 12);
            access(1'b1, 12'h490, 32'h5a); chk(56'(err), 56'(c / 2), "override");
            clr;
            burn(12'h490, c % 2 == 0);
            clr;
            burn(12'h620, c == 0);
            clr;
        end
        ld(12'h400, 32'hffffffff);
        access(1'b1, 12'h630, 32'h0); chk(56'(err), 56'h0, "unlocked write");
        access(1'b0, 12'h600, 32'h0); chk(56'({rd, err}), 56'h175b575b5, "poison");
        clr;
        access(1'b0, 12'h123, 32'h0); chk(56'({rd, err}), 56'h0, "unmapped");
        access(1'b1, 12'h400, 32'h0); chk(56'(err), 56'h1, "lock word write");
        clr;
        burn(12'h600, 1'b0);
        complete_run;
    end
endmodule
`default_nettype wire
